// ### common/cpu_mode_pkg.sv
// Constants shared by the mode-dependent control logic of the processor core.
// Assumes a single 250 MHz clock domain; nothing here is synthesised on its own.
package cpu_mode_pkg;
  // Register port map, 16-bit data
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_STACK = 4'h1;
  localparam logic [3:0] REG_ACC = 4'h2;
  localparam logic [3:0] REG_FLAGS = 4'h3;
  // Mode register fields
  localparam int MODE_EMU_BIT = 0;
  localparam int MODE_ACC8_BIT = 1;
  localparam int MODE_IDX8_BIT = 2;
  localparam int MODE_DEC_BIT = 3;
  localparam int MODE_IRQ_MASK_BIT = 4;
  // Status byte positions
  localparam int ST_N = 7;
  localparam int ST_V = 6;
  localparam int ST_M = 5;
  localparam int ST_X = 4;
  localparam int ST_D = 3;
  localparam int ST_I = 2;
  localparam int ST_Z = 1;
  localparam int ST_C = 0;
  // Reset values
  localparam logic [15:0] SP_RESET = 16'h01FF;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  // Vectors
  localparam logic [23:0] VEC_EMU_BRK_IRQ = 24'h00FFFE;
  localparam logic [23:0] VEC_NATIVE_BRK = 24'h00FFE6;
  localparam logic [7:0] RESERVED_OPCODE = 8'h42;
  typedef enum logic [1:0] {INT_BREAK, INT_IRQ, INT_NMI, INT_ABORT} int_kind_t;
  typedef enum logic [1:0] {RMW_IDLE, RMW_READ, RMW_MODIFY, RMW_WRITE} rmw_phase_t;
endpackage

// ### common/alu_if.sv
// Operand and result bundle between the mode controller and its adder.
// Purely combinational signals on the controller's clock.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  logic [15:0] a;
  logic [15:0] b;
  logic carry_in;
  logic decimal;
  logic wide;
  logic [15:0] sum;
  logic carry_out;
  logic overflow;
  modport host (output a, output b, output carry_in, output decimal, output wide,
                input sum, input carry_out, input overflow);
  modport unit (input a, input b, input carry_in, input decimal, input wide,
                output sum, output carry_out, output overflow);
endinterface
`default_nettype wire

// ### design/decimal_adder.sv
// Binary or decimal adder, 8 or 16 bits wide, four nibble stages.
// Combinational; the caller registers its results.
`timescale 1ns/1ps
`default_nettype none
module decimal_adder (
  alu_if.unit bus
);
  wire [4:0] carry;
  wire [15:0] sum_w;
  wire msb_a;
  wire msb_b;
  wire msb_s;

  assign carry[0] = bus.carry_in;

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_nibble
      wire [4:0] raw;
      wire adjust;
      wire [4:0] fixed;
      assign raw = {1'b0, bus.a[4*i +: 4]} + {1'b0, bus.b[4*i +: 4]} + {4'h0, carry[i]};
      // Nibble above nine is brought back into range in decimal mode
      assign adjust = bus.decimal && (raw > 5'h09);
      assign fixed = adjust ? raw + 5'h06 : raw;
      assign sum_w[4*i +: 4] = fixed[3:0];
      assign carry[i+1] = adjust | raw[4];
    end
  endgenerate

  assign msb_a = bus.wide ? bus.a[15] : bus.a[7];
  assign msb_b = bus.wide ? bus.b[15] : bus.b[7];
  assign msb_s = bus.wide ? sum_w[15] : sum_w[7];
  assign bus.sum = sum_w;
  assign bus.carry_out = bus.wide ? carry[4] : carry[2];
  assign bus.overflow = (msb_a == msb_b) && (msb_s != msb_a);
endmodule // decimal_adder
`default_nettype wire

// ### design/cpu_mode_ctrl.sv
// Mode-dependent control of the processor core: stack, direct page, accumulator,
// interrupt entry and return, read-modify-write bus lines and page-crossing reads.
// Assumes all core-side strobes come from logic on clk and last one cycle.
//
// Summary of operation
// - Emulation keeps stack pointer in page 1, 8 bits; native uses 16 bits.
// - Direct-page indexing wraps inside the page in emulation, carries in native.
// - Accumulator is 8 bits when width flag set, 16 bits when clear.
// - Decimal add gives valid N, V, Z; decimal flag cleared on reset and interrupt.
// - Emulation break/IRQ vector 00FFFE, break bit 0 for hardware; native break vector 00FFE6.
// - Program bank pushed on entry and pulled on return only in native mode.
// - Memory lock held low through read, modify and write of read-modify-write.
// - Indexed page crossing adds a dummy read of the uncorrected address.
// - Program bank is zero after reset and after any interrupt entry.
// - Read/write low in modify and write when emulating, only write when native.
// - Reserved opcode is a no-operation; registers and flags unchanged.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_ctrl #(
  parameter logic [23:0] irq_vector_native = 24'h000000,
  parameter logic [23:0] nmi_vector = 24'h000000,
  parameter logic [23:0] abort_vector = 24'h000000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic stack_push,
  input wire logic stack_pull,
  output logic [15:0] stack_ptr,
  input wire logic dp_req,
  input wire logic [15:0] direct_page,
  input wire logic [7:0] dp_offset,
  input wire logic [15:0] dp_index,
  output logic [15:0] dp_addr,
  output logic dp_valid,
  input wire logic ix_req,
  input wire logic [23:0] ix_base,
  input wire logic [15:0] ix_index,
  output logic [23:0] ix_addr,
  output logic [23:0] ix_dummy_addr,
  output logic ix_dummy,
  output logic ix_valid,
  input wire logic alu_req,
  input wire logic [7:0] opcode,
  input wire logic [15:0] operand,
  output logic [15:0] accumulator,
  output logic reserved_nop,
  input wire logic int_req,
  input wire cpu_mode_pkg::int_kind_t int_kind,
  output logic [23:0] vector_addr,
  output logic [7:0] pushed_status,
  output logic push_bank,
  output logic entry_done,
  input wire logic rti_req,
  input wire logic [7:0] rti_bank,
  output logic pull_bank,
  output logic rti_done,
  input wire logic bank_load,
  input wire logic [7:0] bank_value,
  output logic [7:0] program_bank,
  input wire cpu_mode_pkg::rmw_phase_t rmw_phase,
  output logic memory_lock_n,
  output logic rw_n,
  output logic emulation_mode,
  output logic acc_8bit,
  output logic index_8bit,
  output logic decimal_mode
);
  alu_if alu ();

  logic e_q, m_q, x_q, d_q, i_q, n_q, v_q, z_q, c_q;
  logic [15:0] sp_q, acc_q;
  logic [7:0] bank_q;

  // Register port decode
  wire wr_mode = reg_wr && (reg_addr == cpu_mode_pkg::REG_MODE);
  wire wr_stack = reg_wr && (reg_addr == cpu_mode_pkg::REG_STACK);
  wire wr_acc = reg_wr && (reg_addr == cpu_mode_pkg::REG_ACC);
  wire is_reserved = (opcode == cpu_mode_pkg::RESERVED_OPCODE);
  wire alu_go = alu_req && !is_reserved;

  // Mode flags; emulation forces both width flags to 8 bits
  wire e_d = wr_mode ? reg_wdata[cpu_mode_pkg::MODE_EMU_BIT] : e_q;
  wire m_d = e_d | (wr_mode ? reg_wdata[cpu_mode_pkg::MODE_ACC8_BIT] : m_q);
  wire x_d = e_d | (wr_mode ? reg_wdata[cpu_mode_pkg::MODE_IDX8_BIT] : x_q);
  wire d_d = int_req ? 1'b0 : (wr_mode ? reg_wdata[cpu_mode_pkg::MODE_DEC_BIT] : d_q);
  wire i_d = int_req ? 1'b1 : (wr_mode ? reg_wdata[cpu_mode_pkg::MODE_IRQ_MASK_BIT] : i_q);

  // Stack pointer
  wire [15:0] sp_step = stack_push ? sp_q - 16'h0001 : sp_q + 16'h0001;
  wire sp_move = stack_push ^ stack_pull;
  wire [15:0] sp_raw = wr_stack ? reg_wdata : (sp_move ? sp_step : sp_q);
  wire [15:0] sp_d = e_d ? {cpu_mode_pkg::STACK_PAGE, sp_raw[7:0]} : sp_raw;

  // Direct page indexed address
  wire [15:0] dp_idx = x_q ? {8'h00, dp_index[7:0]} : dp_index;
  wire [15:0] dp_full = direct_page + {8'h00, dp_offset} + dp_idx;
  wire [15:0] dp_d = e_q ? {direct_page[15:8], dp_full[7:0]} : dp_full;

  // Indexed page crossing
  wire [15:0] ix_idx = x_q ? {8'h00, ix_index[7:0]} : ix_index;
  wire [23:0] ix_sum = ix_base + {8'h00, ix_idx};
  wire ix_cross = (ix_sum[23:8] != ix_base[23:8]);
  wire [23:0] ix_uncorrected = {ix_base[23:8], ix_sum[7:0]};

  // Accumulator through the adder
  assign alu.a = m_q ? {8'h00, acc_q[7:0]} : acc_q;
  assign alu.b = m_q ? {8'h00, operand[7:0]} : operand;
  assign alu.carry_in = c_q;
  assign alu.decimal = d_q;
  assign alu.wide = !m_q;
  wire [15:0] acc_alu = m_q ? {acc_q[15:8], alu.sum[7:0]} : alu.sum;
  wire [15:0] acc_wr = m_q ? {acc_q[15:8], reg_wdata[7:0]} : reg_wdata;
  wire [15:0] acc_d = alu_go ? acc_alu : (wr_acc ? acc_wr : acc_q);
  wire res_n = m_q ? alu.sum[7] : alu.sum[15];
  wire res_z = m_q ? (alu.sum[7:0] == 8'h00) : (alu.sum == 16'h0000);

  decimal_adder u_adder (
    .bus (alu.unit)
  );

  // Interrupt entry
  wire is_hw = (int_kind != cpu_mode_pkg::INT_BREAK);
  wire [23:0] vec_emu = (int_kind == cpu_mode_pkg::INT_NMI) ? nmi_vector :
                        (int_kind == cpu_mode_pkg::INT_ABORT) ? abort_vector :
                        cpu_mode_pkg::VEC_EMU_BRK_IRQ;
  wire [23:0] vec_nat = (int_kind == cpu_mode_pkg::INT_BREAK) ? cpu_mode_pkg::VEC_NATIVE_BRK :
                        (int_kind == cpu_mode_pkg::INT_IRQ) ? irq_vector_native :
                        (int_kind == cpu_mode_pkg::INT_NMI) ? nmi_vector : abort_vector;
  wire [23:0] vec_d = e_q ? vec_emu : vec_nat;
  wire [7:0] status_now = {n_q, v_q, m_q, x_q, d_q, i_q, z_q, c_q};
  // Emulation: bit 5 reads one, bit 4 is the break marker
  wire [7:0] status_emu = {n_q, v_q, 1'b1, !is_hw, d_q, i_q, z_q, c_q};
  wire [7:0] status_d = e_q ? status_emu : status_now;

  // Program bank: entry zeroes it, return restores it only in native mode
  wire [7:0] bank_d = int_req ? cpu_mode_pkg::BANK_RESET :
                      (rti_req && !e_q) ? rti_bank :
                      bank_load ? bank_value : bank_q;

  // Read-modify-write bus lines
  wire lock_d = (rmw_phase == cpu_mode_pkg::RMW_IDLE);
  wire rw_d = !((rmw_phase == cpu_mode_pkg::RMW_WRITE) ||
                ((rmw_phase == cpu_mode_pkg::RMW_MODIFY) && e_q));

  // Read data
  wire [15:0] mode_word = {11'h000, i_q, d_q, x_q, m_q, e_q};
  wire [15:0] rd_d = (reg_addr == cpu_mode_pkg::REG_MODE) ? mode_word :
                     (reg_addr == cpu_mode_pkg::REG_STACK) ? sp_q :
                     (reg_addr == cpu_mode_pkg::REG_ACC) ? acc_q :
                     (reg_addr == cpu_mode_pkg::REG_FLAGS) ? {bank_q, status_now} : 16'h0000;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      e_q <= 1'b1;
      m_q <= 1'b1;
      x_q <= 1'b1;
      d_q <= 1'b0;
      i_q <= 1'b1;
      sp_q <= cpu_mode_pkg::SP_RESET;
      bank_q <= cpu_mode_pkg::BANK_RESET;
    end
    else
    begin
      e_q <= e_d;
      m_q <= m_d;
      x_q <= x_d;
      d_q <= d_d;
      i_q <= i_d;
      sp_q <= sp_d;
      bank_q <= bank_d;
    end
  end

  // Arithmetic state; the reserved opcode leaves it untouched
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q <= cpu_mode_pkg::ACC_RESET;
      {n_q, v_q, z_q, c_q} <= 4'h0;
    end
    else
    begin
      acc_q <= acc_d;
      if (alu_go)
      begin
        {n_q, v_q, z_q, c_q} <= {res_n, alu.overflow, res_z, alu.carry_out};
      end
    end
  end

  // Address and event outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_addr <= 16'h0000;
      dp_valid <= 1'b0;
      ix_addr <= 24'h000000;
      ix_dummy_addr <= 24'h000000;
      ix_dummy <= 1'b0;
      ix_valid <= 1'b0;
      reserved_nop <= 1'b0;
      vector_addr <= 24'h000000;
      pushed_status <= 8'h00;
      push_bank <= 1'b0;
      entry_done <= 1'b0;
      pull_bank <= 1'b0;
      rti_done <= 1'b0;
    end
    else
    begin
      dp_valid <= dp_req;
      if (dp_req)
      begin
        dp_addr <= dp_d;
      end
      ix_valid <= ix_req;
      ix_dummy <= ix_req && ix_cross;
      if (ix_req)
      begin
        ix_addr <= ix_sum;
        ix_dummy_addr <= ix_uncorrected;
      end
      reserved_nop <= alu_req && is_reserved;
      entry_done <= int_req;
      push_bank <= int_req && !e_q;
      if (int_req)
      begin
        vector_addr <= vec_d;
        pushed_status <= status_d;
      end
      rti_done <= rti_req;
      pull_bank <= rti_req && !e_q;
    end
  end

  // Register-backed outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 16'h0000;
      memory_lock_n <= 1'b1;
      rw_n <= 1'b1;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_d : 16'h0000;
      memory_lock_n <= lock_d;
      rw_n <= rw_d;
    end
  end

  assign stack_ptr = sp_q;
  assign accumulator = acc_q;
  assign program_bank = bank_q;
  assign emulation_mode = e_q;
  assign acc_8bit = m_q;
  assign index_8bit = x_q;
  assign decimal_mode = d_q;
endmodule // cpu_mode_ctrl
`default_nettype wire

// ### test/cpu_mode_properties.sv
// Timing checks on the mode controller's ports.
// Assumes one clock domain and registered outputs one cycle behind requests.
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire cpu_mode_pkg::rmw_phase_t rmw_phase,
  input wire cpu_mode_pkg::int_kind_t int_kind,
  input wire logic memory_lock_n,
  input wire logic rw_n,
  input wire logic emulation_mode,
  input wire logic [15:0] stack_ptr,
  input wire logic int_req,
  input wire logic [23:0] vector_addr,
  input wire logic push_bank,
  input wire logic entry_done,
  input wire logic [7:0] program_bank,
  input wire logic decimal_mode,
  input wire logic ix_valid,
  input wire logic ix_dummy,
  input wire logic [23:0] ix_addr,
  input wire logic [23:0] ix_dummy_addr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_modify(e);
    rmw_phase == cpu_mode_pkg::RMW_MODIFY && emulation_mode == e;
  endsequence
  sequence s_int(e, k);
    int_req && emulation_mode == e && int_kind == k;
  endsequence
  AST_LOCK: assert property (rmw_phase != cpu_mode_pkg::RMW_IDLE |=> !memory_lock_n)
    else $error("lock not low during read-modify-write");
  AST_RW_EMU: assert property (s_modify(1'b1) |=> !rw_n)
    else $error("write line high in emulated modify cycle");
  AST_RW_NAT: assert property (s_modify(1'b0) |=> rw_n)
    else $error("write line low in native modify cycle");
  AST_SP_EMU: assert property (emulation_mode |-> stack_ptr[15:8] == cpu_mode_pkg::STACK_PAGE)
    else $error("stack left page one while emulating");
  AST_VEC_EMU: assert property (s_int(1'b1, cpu_mode_pkg::INT_IRQ) or s_int(1'b1, cpu_mode_pkg::INT_BREAK)
    |=> vector_addr == cpu_mode_pkg::VEC_EMU_BRK_IRQ && !push_bank)
    else $error("wrong emulated vector or bank pushed");
  AST_VEC_NAT: assert property (s_int(1'b0, cpu_mode_pkg::INT_BREAK)
    |=> vector_addr == cpu_mode_pkg::VEC_NATIVE_BRK && push_bank)
    else $error("wrong native break vector or bank not pushed");
  AST_ENTRY: assert property (int_req |=> entry_done && program_bank == 8'h00 && !decimal_mode)
    else $error("entry did not clear bank and decimal flag");
  AST_DUMMY: assert property (ix_valid && ix_dummy
    |-> ix_dummy_addr[7:0] == ix_addr[7:0] && ix_dummy_addr[23:8] != ix_addr[23:8])
    else $error("dummy address not the uncorrected one");
endmodule // cpu_mode_props
bind cpu_mode_ctrl cpu_mode_props cpu_mode_props_i (.clk, .reset_n, .rmw_phase, .int_kind, .memory_lock_n,
  .rw_n, .emulation_mode, .stack_ptr, .int_req, .vector_addr, .push_bank, .entry_done, .program_bank,
  .decimal_mode, .ix_valid, .ix_dummy, .ix_addr, .ix_dummy_addr);
`default_nettype wire

// ### test/bus_memory_model.sv
// Memory on the system bus: counts locked and written cycles.
// Samples the bus lines on each rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model (
  input wire logic clk,
  input wire logic memory_lock_n,
  input wire logic rw_n,
  output var int lock_cycles,
  output var int write_cycles
);
  // Counters start at zero as two-state variables; one process drives each
  always @(posedge clk)
  begin
    if (!memory_lock_n)
      lock_cycles <= lock_cycles + 1;
    if (!rw_n)
      write_cycles <= write_cycles + 1;
  end
endmodule // bus_memory_model
`default_nettype wire

// ### test/cpu_mode_dependent_behaviour_bench.sv
// Self-checking bench for the mode controller.
// Drives the register port and core strobes; bus memory model counts cycles.
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_dependent_behaviour_bench;
  logic clk, reset_n, reg_wr, reg_rd, stack_push, stack_pull, dp_req, ix_req, alu_req, int_req, rti_req, bank_load;
  logic [3:0] reg_addr;
  logic [7:0] dp_offset, opcode, rti_bank, bank_value, pushed_status, program_bank;
  logic [15:0] reg_wdata, direct_page, dp_index, ix_index, operand, reg_rdata, stack_ptr, dp_addr, accumulator;
  logic [23:0] ix_base, ix_addr, ix_dummy_addr, vector_addr;
  logic dp_valid, ix_dummy, ix_valid, reserved_nop, push_bank, entry_done, pull_bank, rti_done;
  logic memory_lock_n, rw_n, emulation_mode, acc_8bit, index_8bit, decimal_mode;
  cpu_mode_pkg::int_kind_t int_kind;
  cpu_mode_pkg::rmw_phase_t rmw_phase;
  int n_mismatch, cmp_count, cyc, lock_cycles, write_cycles, l0, w0;
  cpu_mode_ctrl cpu_mode_ctrl_i (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stack_push,
    .stack_pull, .stack_ptr, .dp_req, .direct_page, .dp_offset, .dp_index, .dp_addr, .dp_valid, .ix_req, .ix_base,
    .ix_index, .ix_addr, .ix_dummy_addr, .ix_dummy, .ix_valid, .alu_req, .opcode, .operand, .accumulator,
    .reserved_nop, .int_req, .int_kind, .vector_addr, .pushed_status, .push_bank, .entry_done, .rti_req, .rti_bank,
    .pull_bank, .rti_done, .bank_load, .bank_value, .program_bank, .rmw_phase, .memory_lock_n, .rw_n,
    .emulation_mode, .acc_8bit, .index_8bit, .decimal_mode);
  bus_memory_model bus_memory_model_i (.clk, .memory_lock_n, .rw_n, .lock_cycles, .write_cycles);
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  // One-cycle core strobe, then look at the answering cycle
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: stack_push <= 1'b1;
      1: stack_pull <= 1'b1;
      2: dp_req <= 1'b1;
      3: ix_req <= 1'b1;
      4: alu_req <= 1'b1;
      5: int_req <= 1'b1;
      6: rti_req <= 1'b1;
      default: bank_load <= 1'b1;
    endcase
    @(posedge clk);
    {stack_push, stack_pull, dp_req, ix_req, alu_req, int_req, rti_req, bank_load} <= 8'h00;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial
  begin
    {reset_n, reg_wr, reg_rd, stack_push, stack_pull, dp_req, ix_req, alu_req, int_req, rti_req, bank_load} = 11'h000;
    {reg_addr, dp_offset, opcode, rti_bank, bank_value} = 36'h0;
    {reg_wdata, direct_page, dp_index, ix_index, operand, ix_base} = 104'h0;
    int_kind = cpu_mode_pkg::INT_BREAK;
    rmw_phase = cpu_mode_pkg::RMW_IDLE;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(cpu_mode_pkg::REG_MODE, 16'h0017);
    rd(cpu_mode_pkg::REG_STACK, 16'h01FF);
    rd(cpu_mode_pkg::REG_FLAGS, 16'h0034);
    rd(4'hF, 16'h0000);
    $display("test reset done");
    pulse(1);
    chk("stack_ptr", 16'h0100, stack_ptr);
    wr(cpu_mode_pkg::REG_MODE, 16'h0000);
    pulse(0);
    chk("stack_ptr", 16'h00FF, stack_ptr);
    chk("emulation_mode", 1'b0, emulation_mode);
    chk("acc_8bit", 1'b0, acc_8bit);
    chk("index_8bit", 1'b0, index_8bit);
    wr(cpu_mode_pkg::REG_MODE, 16'h0001);
    #1 chk("stack_ptr", 16'h01FF, stack_ptr);
    chk("emulation_mode", 1'b1, emulation_mode);
    chk("acc_8bit", 1'b1, acc_8bit);
    chk("index_8bit", 1'b1, index_8bit);
    rd(cpu_mode_pkg::REG_MODE, 16'h0007);
    $display("test stack done");
    dp_offset <= 8'hF0;
    dp_index <= 16'h0020;
    pulse(2);
    chk("dp_addr", 16'h0010, dp_addr);
    chk("dp_valid", 1'b1, dp_valid);
    wr(cpu_mode_pkg::REG_MODE, 16'h0000);
    pulse(2);
    chk("dp_addr", 16'h0110, dp_addr);
    $display("test direct page done");
    wr(cpu_mode_pkg::REG_ACC, 16'hABCD);
    rd(cpu_mode_pkg::REG_ACC, 16'hABCD);
    wr(cpu_mode_pkg::REG_MODE, 16'h0001);
    wr(cpu_mode_pkg::REG_ACC, 16'h1234);
    rd(cpu_mode_pkg::REG_ACC, 16'hAB34);
    opcode <= cpu_mode_pkg::RESERVED_OPCODE;
    operand <= 16'h1111;
    pulse(4);
    chk("reserved_nop", 1'b1, reserved_nop);
    chk("accumulator", 16'hAB34, accumulator);
    // Decimal 8-bit add: 34 + 66 gives 00 with carry, high byte kept
    opcode <= 8'h00;
    operand <= 16'h0066;
    wr(cpu_mode_pkg::REG_MODE, 16'h0009);
    pulse(4);
    chk("accumulator", 16'hAB00, accumulator);
    rd(cpu_mode_pkg::REG_FLAGS, 16'h003B);
    // Binary 16-bit add with carry in: AB00 + 5500 + 1
    operand <= 16'h5500;
    wr(cpu_mode_pkg::REG_MODE, 16'h0000);
    pulse(4);
    chk("accumulator", 16'h0001, accumulator);
    rd(cpu_mode_pkg::REG_FLAGS, 16'h0001);
    $display("test accumulator done");
    wr(cpu_mode_pkg::REG_MODE, 16'h000F);
    bank_value <= 8'h5A;
    pulse(7);
    chk("program_bank", 8'h5A, program_bank);
    for (int k = 0; k < 4; k++)
    begin
      int_kind <= cpu_mode_pkg::int_kind_t'(k[1:0]);
      pulse(5);
      chk("entry_done", 1'b1, entry_done);
      chk("break_bit", k == 0, pushed_status[cpu_mode_pkg::ST_X]);
      chk("push_bank", 1'b0, push_bank);
      chk("program_bank", 8'h00, program_bank);
      chk("decimal_mode", 1'b0, decimal_mode);
      if (k < 2) chk("vector_addr", cpu_mode_pkg::VEC_EMU_BRK_IRQ, vector_addr);
    end
    wr(cpu_mode_pkg::REG_MODE, 16'h0000);
    int_kind <= cpu_mode_pkg::INT_BREAK;
    pulse(5);
    chk("vector_addr", cpu_mode_pkg::VEC_NATIVE_BRK, vector_addr);
    chk("index_bit", 1'b0, pushed_status[cpu_mode_pkg::ST_X]);
    chk("push_bank", 1'b1, push_bank);
    rti_bank <= 8'h33;
    pulse(6);
    chk("pull_bank", 1'b1, pull_bank);
    chk("rti_done", 1'b1, rti_done);
    chk("program_bank", 8'h33, program_bank);
    wr(cpu_mode_pkg::REG_MODE, 16'h0001);
    rti_bank <= 8'hC4;
    pulse(6);
    chk("pull_bank", 1'b0, pull_bank);
    chk("program_bank", 8'h33, program_bank);
    $display("test interrupt done");
    ix_base <= 24'h0012F0;
    ix_index <= 16'h0020;
    pulse(3);
    chk("ix_dummy", 1'b1, ix_dummy);
    chk("ix_valid", 1'b1, ix_valid);
    chk("ix_addr", 24'h001310, ix_addr);
    chk("ix_dummy_addr", 24'h001210, ix_dummy_addr);
    ix_index <= 16'h0005;
    pulse(3);
    chk("ix_dummy", 1'b0, ix_dummy);
    $display("test indexing done");
    for (int e = 1; e >= 0; e--)
    begin
      wr(cpu_mode_pkg::REG_MODE, 16'(e));
      l0 = lock_cycles;
      w0 = write_cycles;
      for (int p = 1; p <= 4; p++)
      begin
        @(posedge clk);
        rmw_phase <= cpu_mode_pkg::rmw_phase_t'(p[1:0]);
      end
      repeat (2) @(posedge clk);
      #1 chk("lock_cycles", 24'd3, 24'(lock_cycles - l0));
      chk("write_cycles", 24'(1 + e), 24'(write_cycles - w0));
    end
    $display("test read-modify-write done");
    tally_and_finish;
  end
endmodule // cpu_mode_dependent_behaviour_bench
`default_nettype wire
